/* hdl/smmc_regs.svh */
// Register offsets, field positions, opcodes and fixed values of the management controller
`ifndef SMMC_REGS_SVH
`define SMMC_REGS_SVH
`define SMMC_OFF_CFG1      8'h00
`define SMMC_OFF_CFG3      8'h04
`define SMMC_OFF_CFG6      8'h08
`define SMMC_OFF_REGION    8'h0C
`define SMMC_OFF_HPTR      8'h10
`define SMMC_OFF_STATUS    8'h14
`define SMMC_CFG1_EN_BIT   1
`define SMMC_CFG1_SM_BIT   7
`define SMMC_CFG3_NMIEN    1
`define SMMC_CFG6_ENH_BIT  0
`define SMMC_HPTR_V_BIT    0
`define SMMC_HPTR_LSB      2
`define SMMC_SIZE_MSB      3
`define SMMC_BASE_MASK     32'hFFFFF000
`define SMMC_SIZE_UNIT     32'h00000800
`define SMMC_CS_LIMIT      32'hFFFFFFFF
`define SMMC_ZERO32        32'h00000000
`define SMMC_CFG_RST       8'h00
`define SMMC_OP_SEG_SV     8'h78
`define SMMC_OP_SEG_RS     8'h79
`define SMMC_OP_LDT_SV     8'h7A
`define SMMC_OP_LDT_RS     8'h7B
`define SMMC_OP_TSK_SV     8'h7C
`define SMMC_OP_TSK_RS     8'h7D
`define SMMC_OP_SOFT_ENT   8'h38
`define SMMC_OP_RESUME     8'hAA
`define SMMC_OP_HPTR_RD    8'h36
`define SMMC_OP_HPTR_WR    8'h37
`define SMMC_SREG_CS       3'h1
`define SMMC_SREG_MAX      3'h5
`define SMMC_REG_ZERO      3'h0
`define SMMC_MOD_REG       2'h3
`define SMMC_DESC_BITS     7'h50
`define SMMC_SEL_SEG       2'h0
`define SMMC_SEL_LDT       2'h1
`define SMMC_SEL_TSK       2'h2
`endif

/* hdl/smmc_pkg.sv */
// Types shared by the management controller modules
package smmc_pkg;
	typedef enum logic [3:0] {
		K_NONE, K_SEG_SAVE, K_SEG_REST, K_LDT_SAVE, K_LDT_REST, K_TSK_SAVE, K_TSK_REST,
		K_SOFT_ENTRY, K_RESUME, K_HPTR_RD, K_HPTR_WR
	} smmc_op_t;
	typedef enum logic [6:0] {
		ST_IDLE    = 7'h01,
		ST_ACK     = 7'h02,
		ST_SAVE    = 7'h04,
		ST_FORCE   = 7'h08,
		ST_RUN     = 7'h10,
		ST_RESTORE = 7'h20,
		ST_EXIT    = 7'h40
	} smmc_state_t;
endpackage

/* hdl/smmc_dec_if.sv */
// Opcode decode carrier between controller and decoder
`timescale 1ns/1ns
`default_nettype none
interface smmc_dec_if;
	logic [7:0]         code;
	logic [7:0]         modrm;
	smmc_pkg::smmc_op_t kind;
	logic               bad_form;
	logic [2:0]         sreg;
	modport dec (input code, input modrm, output kind, output bad_form, output sreg);
	modport ctl (output code, output modrm, input kind, input bad_form, input sreg);
endinterface
`default_nettype wire

/* hdl/smmc_decode.sv */
// Decoder for the management opcodes (second byte after 0F)
`timescale 1ns/1ns
`default_nettype none
`include "smmc_regs.svh"
module smmc_decode (
	smmc_dec_if.dec d
);
	logic [2:0] reg_f;
	assign reg_f  = d.modrm[5:3];
	assign d.sreg = reg_f;
	always_comb begin
		d.kind     = smmc_pkg::K_NONE;
		d.bad_form = 1'h0;
		case (d.code)
			`SMMC_OP_SEG_SV: begin
				d.kind     = smmc_pkg::K_SEG_SAVE;
				d.bad_form = reg_f > `SMMC_SREG_MAX;
			end
			`SMMC_OP_SEG_RS: begin
				d.kind     = smmc_pkg::K_SEG_REST;
				// Code segment only comes back through resume
				d.bad_form = (reg_f > `SMMC_SREG_MAX) || (reg_f == `SMMC_SREG_CS);
			end
			`SMMC_OP_LDT_SV: begin
				d.kind     = smmc_pkg::K_LDT_SAVE;
				d.bad_form = reg_f != `SMMC_REG_ZERO;
			end
			`SMMC_OP_LDT_RS: begin
				d.kind     = smmc_pkg::K_LDT_REST;
				d.bad_form = reg_f != `SMMC_REG_ZERO;
			end
			`SMMC_OP_TSK_SV: begin
				d.kind     = smmc_pkg::K_TSK_SAVE;
				d.bad_form = reg_f != `SMMC_REG_ZERO;
			end
			`SMMC_OP_TSK_RS: begin
				d.kind     = smmc_pkg::K_TSK_REST;
				d.bad_form = reg_f != `SMMC_REG_ZERO;
			end
			`SMMC_OP_SOFT_ENT: d.kind = smmc_pkg::K_SOFT_ENTRY;
			`SMMC_OP_RESUME:   d.kind = smmc_pkg::K_RESUME;
			`SMMC_OP_HPTR_RD:  d.kind = smmc_pkg::K_HPTR_RD;
			`SMMC_OP_HPTR_WR:  d.kind = smmc_pkg::K_HPTR_WR;
			default:           d.kind = smmc_pkg::K_NONE;
		endcase
	end
endmodule // smmc_decode
`default_nettype wire

/* hdl/smmc_top.sv */
// Management mode controller: entry, opcode gating, resume, space pin and APB registers
`timescale 1ns/1ns
`default_nettype none
`include "smmc_regs.svh"
module smmc_top #(
	parameter int ADDR_W = 8
) (
	input  wire logic              mclk,
	input  wire logic              reset,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              mgmt_interrupt_pin,
	input  wire logic              nmi_event,
	input  wire logic              maskable_interrupt_pin,
	input  wire logic              flags_if,
	input  wire logic              op_valid,
	input  wire logic [7:0]        op_code,
	input  wire logic [7:0]        op_modrm,
	input  wire logic [1:0]        current_privilege,
	input  wire logic [31:0]       op_operand,
	output logic                   op_busy,
	output logic                   op_done,
	output logic                   op_invalid,
	output logic      [31:0]       op_result,
	output logic                   op_mem,
	output logic                   desc_req,
	output logic                   desc_restore,
	output logic      [1:0]        desc_sel,
	output logic      [2:0]        desc_sreg,
	output logic      [6:0]        desc_bits,
	output logic                   hdr_save_req,
	output logic                   hdr_restore_req,
	output logic      [31:0]       hdr_addr,
	input  wire logic              hdr_done,
	input  wire logic [31:0]       resume_pointer_field,
	output logic      [31:0]       instruction_pointer,
	output logic                   ip_load,
	output logic                   entry_force,
	output logic      [31:0]       cs_base,
	output logic      [31:0]       cs_limit,
	output logic                   ack_cycle_req,
	input  wire logic              ack_done,
	input  wire logic              bus_last_mgmt_done,
	output logic                   mgmt_space_pin,
	input  wire logic              wb_req,
	input  wire logic              wb_line_mgmt_tag,
	output logic                   wb_mgmt_space,
	output logic                   mgmt_cacheable,
	output logic                   mgmt_access_ok,
	output logic                   nmi_service,
	output logic                   maskable_interrupt_pin_service,
	output logic                   in_mgmt_mode
);
	smmc_pkg::smmc_state_t state_r;
	logic [7:0]  cfg1_r, cfg3_r, cfg6_r;
	logic [31:0] region_r, hptr_r, prdata_r;
	logic        smi_prev_r, smi_pend_r, nmi_lat_r, in_mode_r, space_r;
	logic        op_done_r, op_invalid_r, op_mem_r, desc_req_r, desc_restore_r;
	logic [1:0]  desc_sel_r;
	logic [2:0]  desc_sreg_r;
	logic [31:0] op_result_r, ip_r, cs_base_r, cs_limit_r;
	logic        ip_load_r, force_r, wb_space_r, nmi_srv_r, maskable_interrupt_pin_srv_r;
	smmc_dec_if u_if ();
	assign u_if.code  = op_code;
	assign u_if.modrm = op_modrm;
	smmc_decode u_dec (
		.d (u_if)
	);

	logic        idle, run, recog, op_allowed, accept, is_mgmt, gate_ok, good, bad;
	logic        go, rsm_go, smi_fall, enh, nmi_allow, int_window, nmi_take, maskable_interrupt_pin_take;
	logic        wr_en, rd_setup, hit, region_wr;
	logic [31:0] base, region_bytes, hptr_calc, rd_mux;
	smmc_pkg::smmc_op_t kind;
	assign kind         = u_if.kind;
	assign idle         = state_r == smmc_pkg::ST_IDLE;
	assign run          = state_r == smmc_pkg::ST_RUN;
	assign enh          = cfg6_r[`SMMC_CFG6_ENH_BIT];
	assign base         = region_r & `SMMC_BASE_MASK;
	assign region_bytes = `SMMC_SIZE_UNIT << region_r[`SMMC_SIZE_MSB:0];
	assign hptr_calc    = base + region_bytes;
	assign recog = cfg1_r[`SMMC_CFG1_EN_BIT] & cfg1_r[`SMMC_CFG1_SM_BIT]
		& (|region_r[`SMMC_SIZE_MSB:0]);
	assign op_allowed = recog & (current_privilege == 2'h0) & in_mode_r;
	// Opcodes are only taken when no entry or exit sequence is in flight
	assign accept  = op_valid & (idle | run);
	assign op_busy = ~(idle | run);
	assign is_mgmt = kind != smmc_pkg::K_NONE;
	always_comb begin
		if (kind == smmc_pkg::K_SOFT_ENTRY)
			gate_ok = recog & ~in_mode_r;
		else
			gate_ok = op_allowed & ~u_if.bad_form;
	end
	assign good   = accept & is_mgmt & gate_ok;
	assign bad    = accept & is_mgmt & ~gate_ok;
	assign smi_fall = smi_prev_r & ~mgmt_interrupt_pin;
	assign go     = idle & (smi_pend_r | (good & (kind == smmc_pkg::K_SOFT_ENTRY)));
	assign rsm_go = good & (kind == smmc_pkg::K_RESUME);

	always_ff @(posedge mclk) begin
		if (reset) begin
			state_r <= smmc_pkg::ST_IDLE;
		end else begin
			case (state_r)
				smmc_pkg::ST_IDLE:    if (go) state_r <= smmc_pkg::ST_ACK;
				smmc_pkg::ST_ACK:     if (ack_done) state_r <= smmc_pkg::ST_SAVE;
				smmc_pkg::ST_SAVE:    if (hdr_done) state_r <= smmc_pkg::ST_FORCE;
				smmc_pkg::ST_FORCE:   state_r <= smmc_pkg::ST_RUN;
				smmc_pkg::ST_RUN:     if (rsm_go) state_r <= smmc_pkg::ST_RESTORE;
				smmc_pkg::ST_RESTORE: if (hdr_done) state_r <= smmc_pkg::ST_EXIT;
				smmc_pkg::ST_EXIT:    if (bus_last_mgmt_done) state_r <= smmc_pkg::ST_IDLE;
				default:              state_r <= smmc_pkg::ST_IDLE;
			endcase
		end
	end

	// Pin sampled every edge; the request latch holds one event, set wins over clear
	always_ff @(posedge mclk) begin
		if (reset) begin
			smi_prev_r <= 1'h1;
			smi_pend_r <= 1'h0;
		end else begin
			smi_prev_r <= mgmt_interrupt_pin;
			if (smi_fall & recog)
				smi_pend_r <= 1'h1;
			else if (go)
				smi_pend_r <= 1'h0;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			in_mode_r <= 1'h0;
			space_r   <= 1'h0;
		end else if (go) begin
			in_mode_r <= 1'h1;
			space_r   <= 1'h1;
		end else if ((state_r == smmc_pkg::ST_EXIT) && bus_last_mgmt_done) begin
			in_mode_r <= 1'h0;
			space_r   <= 1'h0;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			force_r    <= 1'h0;
			cs_base_r  <= `SMMC_ZERO32;
			cs_limit_r <= `SMMC_ZERO32;
		end else begin
			force_r <= state_r == smmc_pkg::ST_FORCE;
			if (state_r == smmc_pkg::ST_FORCE) begin
				cs_base_r  <= base;
				cs_limit_r <= `SMMC_CS_LIMIT;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			ip_r      <= `SMMC_ZERO32;
			ip_load_r <= 1'h0;
		end else begin
			ip_load_r <= (state_r == smmc_pkg::ST_RESTORE) && hdr_done;
			if ((state_r == smmc_pkg::ST_RESTORE) && hdr_done)
				ip_r <= resume_pointer_field;
		end
	end

	// Entry and the pending-request latch outrank NMI, NMI outranks MASKABLE_INTERRUPT_PIN
	assign int_window = (idle | run) & ~smi_pend_r & ~go;
	assign nmi_allow  = ~in_mode_r | cfg3_r[`SMMC_CFG3_NMIEN];
	assign nmi_take   = int_window & nmi_allow & (nmi_event | nmi_lat_r);
	assign maskable_interrupt_pin_take  = int_window & ~nmi_take & ~force_r & maskable_interrupt_pin & flags_if;
	always_ff @(posedge mclk) begin
		if (reset) begin
			nmi_lat_r  <= 1'h0;
			nmi_srv_r  <= 1'h0;
			maskable_interrupt_pin_srv_r <= 1'h0;
		end else begin
			nmi_srv_r  <= nmi_take;
			maskable_interrupt_pin_srv_r <= maskable_interrupt_pin_take;
			if (nmi_event & ~nmi_take)
				nmi_lat_r <= 1'h1;
			else if (nmi_take)
				nmi_lat_r <= 1'h0;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			op_done_r      <= 1'h0;
			op_invalid_r   <= 1'h0;
			op_result_r    <= `SMMC_ZERO32;
			op_mem_r       <= 1'h0;
			desc_req_r     <= 1'h0;
			desc_restore_r <= 1'h0;
			desc_sel_r     <= `SMMC_SEL_SEG;
			desc_sreg_r    <= `SMMC_REG_ZERO;
		end else begin
			op_done_r    <= good;
			op_invalid_r <= bad;
			op_mem_r     <= op_modrm[7:6] != `SMMC_MOD_REG;
			if (good & (kind == smmc_pkg::K_HPTR_RD))
				op_result_r <= hptr_r;
			desc_req_r <= good & (kind inside {smmc_pkg::K_SEG_SAVE, smmc_pkg::K_SEG_REST,
				smmc_pkg::K_LDT_SAVE, smmc_pkg::K_LDT_REST,
				smmc_pkg::K_TSK_SAVE, smmc_pkg::K_TSK_REST});
			desc_restore_r <= kind inside {smmc_pkg::K_SEG_REST, smmc_pkg::K_LDT_REST,
				smmc_pkg::K_TSK_REST};
			desc_sreg_r <= u_if.sreg;
			case (kind)
				smmc_pkg::K_LDT_SAVE, smmc_pkg::K_LDT_REST: desc_sel_r <= `SMMC_SEL_LDT;
				smmc_pkg::K_TSK_SAVE, smmc_pkg::K_TSK_REST: desc_sel_r <= `SMMC_SEL_TSK;
				default:                                    desc_sel_r <= `SMMC_SEL_SEG;
			endcase
		end
	end

	// Region write invalidates the pointer so a later entry recomputes the header spot; an entry in the same cycle keeps the old one
	always_ff @(posedge mclk) begin
		if (reset)
			hptr_r <= `SMMC_ZERO32;
		else if (region_wr)
			hptr_r[`SMMC_HPTR_V_BIT] <= 1'h0;
		else if (good & (kind == smmc_pkg::K_HPTR_WR))
			hptr_r <= op_operand;
		else if (go & ~hptr_r[`SMMC_HPTR_V_BIT])
			hptr_r <= {hptr_calc[31:`SMMC_HPTR_LSB], 2'h1};
	end

	always_ff @(posedge mclk) begin
		if (reset)
			wb_space_r <= 1'h0;
		else
			wb_space_r <= wb_req & (enh ? wb_line_mgmt_tag : in_mode_r);
	end

	assign wr_en     = psel & penable & pwrite;
	assign rd_setup  = psel & ~penable;
	assign region_wr = wr_en & (paddr == `SMMC_OFF_REGION);
	always_comb begin
		hit    = 1'h1;
		rd_mux = `SMMC_ZERO32;
		case (paddr)
			`SMMC_OFF_CFG1:   rd_mux = {24'h0, cfg1_r};
			`SMMC_OFF_CFG3:   rd_mux = {24'h0, cfg3_r};
			`SMMC_OFF_CFG6:   rd_mux = {24'h0, cfg6_r};
			`SMMC_OFF_REGION: rd_mux = region_r;
			`SMMC_OFF_HPTR:   rd_mux = hptr_r;
			`SMMC_OFF_STATUS: rd_mux = {21'h0, state_r, in_mode_r, smi_pend_r, nmi_lat_r,
				hptr_r[`SMMC_HPTR_V_BIT]};
			default:          hit = 1'h0;
		endcase
	end
	always_ff @(posedge mclk) begin
		if (reset) begin
			cfg1_r   <= `SMMC_CFG_RST;
			cfg3_r   <= `SMMC_CFG_RST;
			cfg6_r   <= `SMMC_CFG_RST;
			region_r <= `SMMC_ZERO32;
		end else if (wr_en) begin
			case (paddr)
				`SMMC_OFF_CFG1:   cfg1_r <= pwdata[7:0];
				`SMMC_OFF_CFG3:   cfg3_r <= pwdata[7:0];
				`SMMC_OFF_CFG6:   cfg6_r <= pwdata[7:0];
				`SMMC_OFF_REGION: region_r <= pwdata;
				default:          cfg1_r <= cfg1_r;
			endcase
		end
	end
	always_ff @(posedge mclk) begin
		if (reset)
			prdata_r <= `SMMC_ZERO32;
		else if (rd_setup)
			prdata_r <= rd_mux;
	end

	assign pready          = 1'h1;
	assign pslverr         = psel & penable & ~hit;
	assign prdata          = prdata_r;
	assign op_done         = op_done_r;
	assign op_invalid      = op_invalid_r;
	assign op_result       = op_result_r;
	assign op_mem          = op_mem_r;
	assign desc_req        = desc_req_r;
	assign desc_restore    = desc_restore_r;
	assign desc_sel        = desc_sel_r;
	assign desc_sreg       = desc_sreg_r;
	assign desc_bits       = `SMMC_DESC_BITS;
	assign hdr_save_req    = state_r == smmc_pkg::ST_SAVE;
	assign hdr_restore_req = state_r == smmc_pkg::ST_RESTORE;
	assign hdr_addr        = {hptr_r[31:`SMMC_HPTR_LSB], 2'h0};
	assign instruction_pointer = ip_r;
	assign ip_load         = ip_load_r;
	assign entry_force     = force_r;
	assign cs_base         = cs_base_r;
	assign cs_limit        = cs_limit_r;
	assign ack_cycle_req   = state_r == smmc_pkg::ST_ACK;
	assign mgmt_space_pin  = space_r;
	assign wb_mgmt_space   = wb_space_r;
	// Caching of management space is refused in compatible mode
	assign mgmt_cacheable  = enh;
	assign mgmt_access_ok  = in_mode_r;
	assign nmi_service     = nmi_srv_r;
	assign maskable_interrupt_pin_service    = maskable_interrupt_pin_srv_r;
	assign in_mgmt_mode    = in_mode_r;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	sequence s_entry;
		idle && go;
	endsequence
	sequence s_ack;
		ack_cycle_req && mgmt_space_pin && in_mgmt_mode;
	endsequence
	property p_entry_ack;
		s_entry |=> s_ack;
	endproperty
	a_entry_ack: assert property (p_entry_ack) else $error("entry without ack and space pin");
	property p_fall_latch;
		smi_fall && recog |=> smi_pend_r || ack_cycle_req;
	endproperty
	a_fall_latch: assert property (p_fall_latch) else $error("falling edge lost");
	property p_invalid;
		op_valid && op_busy == 1'h0 && is_mgmt && !gate_ok |=> op_invalid && !op_done;
	endproperty
	a_invalid: assert property (p_invalid) else $error("gate failure not flagged");
	property p_desc_gate;
		desc_req |-> $past(op_allowed) && !$past(u_if.bad_form);
	endproperty
	a_desc_gate: assert property (p_desc_gate) else $error("descriptor move while ungated");
	property p_force;
		state_r == smmc_pkg::ST_FORCE |=> entry_force && cs_limit == `SMMC_CS_LIMIT
			&& cs_base == $past(base) && state_r == smmc_pkg::ST_RUN;
	endproperty
	a_force: assert property (p_force) else $error("entry state not forced");
	property p_ip;
		state_r == smmc_pkg::ST_RESTORE && hdr_done |=> ip_load
			&& instruction_pointer == $past(resume_pointer_field);
	endproperty
	a_ip: assert property (p_ip) else $error("resume pointer not taken");
	property p_nmi_latch;
		nmi_event && in_mode_r && !cfg3_r[`SMMC_CFG3_NMIEN] |=> nmi_lat_r && !nmi_service;
	endproperty
	a_nmi_latch: assert property (p_nmi_latch) else $error("masked NMI not latched");
	property p_prio;
		nmi_service || maskable_interrupt_pin_service |-> !$past(smi_pend_r);
	endproperty
	a_prio: assert property (p_prio) else $error("interrupt served over pending entry");
	property p_wb;
		wb_req && !enh && in_mode_r |=> wb_mgmt_space;
	endproperty
	a_wb: assert property (p_wb) else $error("write-back lacks space pin");
	property p_hptr;
		region_wr |=> !hptr_r[`SMMC_HPTR_V_BIT];
	endproperty
	a_hptr: assert property (p_hptr) else $error("pointer valid survived region write");
	property p_pin_drop;
		state_r == smmc_pkg::ST_EXIT && bus_last_mgmt_done |=> !mgmt_space_pin
			##1 (!mgmt_space_pin || ack_cycle_req);
	endproperty
	a_pin_drop: assert property (p_pin_drop) else $error("space pin not released");
endmodule // smmc_top
`default_nettype wire

/* test/smmc_chipset.sv */
// Chipset model: management pin driver and answers to the bus cycles
`timescale 1ns/1ns
`default_nettype none
module smmc_chipset #(
	parameter int          DLY     = 2,
	parameter logic [31:0] RESUME_POINTER_FIELD = 32'h0000BEE0
) (
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic        fire,
	input  wire logic        ack_cycle_req,
	input  wire logic        hdr_save_req,
	input  wire logic        hdr_restore_req,
	input  wire logic        ip_load,
	input  wire logic        in_mgmt_mode,
	output logic             mgmt_interrupt_pin,
	output logic             ack_done,
	output logic             hdr_done,
	output logic             bus_last_mgmt_done,
	output logic [31:0]      resume_pointer_field
);
	logic [3:0] cnt_r;
	logic [1:0] low_r;
	logic       tail_r;
	wire logic  busy = ack_cycle_req | hdr_save_req | hdr_restore_req;
	always_ff @(posedge mclk) begin
		if (reset)
			low_r <= 2'h0;
		else if (fire)
			low_r <= 2'h2;
		else if (low_r != 2'h0)
			low_r <= low_r - 2'h1;
	end
	// Idles high; a request is a fall held for two edges
	assign mgmt_interrupt_pin = (low_r == 2'h0);
	// Slow answers on purpose, one pulse per request
	always_ff @(posedge mclk) begin
		ack_done <= 1'b0;
		hdr_done <= 1'b0;
		if (reset || !busy || ack_done || hdr_done)
			cnt_r <= 4'h0;
		else if (cnt_r == 4'(DLY)) begin
			ack_done <= ack_cycle_req;
			hdr_done <= hdr_save_req | hdr_restore_req;
			cnt_r <= 4'h0;
		end else
			cnt_r <= cnt_r + 4'h1;
		tail_r <= ip_load & ~reset;
		bus_last_mgmt_done <= tail_r;
	end
	// Header field is not valid outside the mode, so show garbage there
	assign resume_pointer_field = in_mgmt_mode ? RESUME_POINTER_FIELD : ~RESUME_POINTER_FIELD;
endmodule // smmc_chipset
`default_nettype wire

/* test/tb_smmc_top.sv */
// Self-checking bench for the management mode controller
`timescale 1ns/1ns
`default_nettype none
module tb_smmc_top;
	logic mclk, reset, psel, penable, pwrite, pready, pslverr, err, fire;
	logic mgmt_interrupt_pin, nmi_event, maskable_interrupt_pin, flags_if, op_valid;
	logic op_busy, op_done, op_invalid, op_mem, desc_req, desc_restore, hdr_save_req;
	logic hdr_restore_req, hdr_done, ip_load, entry_force, ack_cycle_req, ack_done;
	logic bus_last_mgmt_done, mgmt_space_pin, wb_req, wb_line_mgmt_tag, wb_mgmt_space;
	logic mgmt_cacheable, mgmt_access_ok, nmi_service, maskable_interrupt_pin_service, in_mgmt_mode;
	logic [7:0]  paddr, op_code, op_modrm;
	logic [31:0] pwdata, prdata, op_operand, op_result, hdr_addr, rd;
	logic [31:0] resume_pointer_field, instruction_pointer, cs_base, cs_limit;
	logic [1:0]  desc_sel, current_privilege;
	logic [2:0]  desc_sreg;
	logic [6:0]  desc_bits;
	logic [7:0]  codes [10] = '{8'h38, 8'hAA, 8'h36, 8'h37, 8'h78, 8'h79, 8'h7A, 8'h7B, 8'h7C, 8'h7D};
	int failures, compares, cyc, i;
	smmc_top u_smmc_top (.*);
	smmc_chipset u_smmc_chipset (.*);
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	task stop_test;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			stop_test;
		end
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			failures++;
			$display("BAD %0t got %h expected %h", $time, s, e);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task op(input logic [7:0] c, input logic [7:0] m, input logic ok);
		@(posedge mclk);
		{op_valid, op_code, op_modrm} <= {1'b1, c, m};
		@(posedge mclk);
		op_valid <= 1'b0;
		#1 chk({op_done, op_invalid}, {ok, !ok});
	endtask
	task wb(input logic t, input logic e);
		@(posedge mclk);
		{wb_req, wb_line_mgmt_tag} <= {1'b1, t};
		@(posedge mclk);
		wb_req <= 1'b0;
		#1 chk(wb_mgmt_space, e);
	endtask
	// Waits for the mode flag to reach a level, then for the sequencer to reach idle or run
	task mode(input logic v);
		for (i = 0; i < 100 && in_mgmt_mode !== v; i++) @(posedge mclk) #1;
		for (i = 0; i < 100 && op_busy !== 1'b0; i++) @(posedge mclk) #1;
		chk(in_mgmt_mode, v);
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata, op_valid, op_code, op_modrm} = '0;
		{nmi_event, maskable_interrupt_pin, flags_if, wb_req, wb_line_mgmt_tag, fire} = '0;
		{current_privilege, op_operand} = '0;
		reset = 1'b1;
		repeat (20) @(posedge mclk);
		reset <= 1'b0;
		apb(0, 8'h00, 0);
		chk(rd, 0);
		chk(mgmt_cacheable, 0);
		apb(0, 8'h40, 0);
		chk(err, 1);
		for (int k = 0; k < 10; k++) op(codes[k], 8'hC0, 0);
		fire <= 1'b1;
		@(posedge mclk) fire <= 1'b0;
		repeat (10) @(posedge mclk);
		chk(in_mgmt_mode, 0);
		$display("test gating done");
		apb(1, 8'h0C, 32'h00010001);
		apb(1, 8'h00, 32'h00000082);
		op(8'h38, 8'h00, 1);
		mode(1);
		chk(cs_base, 32'h00010000);
		chk(cs_limit, 32'hFFFFFFFF);
		chk(mgmt_space_pin, 1);
		chk(hdr_addr, 32'h00011000);
		chk(mgmt_access_ok, 1);
		op(8'h36, 8'hC0, 1);
		chk(op_result & 32'hFFFFFFFC, 32'h00011000);
		chk(op_mem, 0);
		op_operand <= 32'h00012001;
		op(8'h37, 8'h00, 1);
		chk(op_mem, 1);
		op(8'h36, 8'hC0, 1);
		chk(op_result & 32'hFFFFFFFC, 32'h00012000);
		op(8'h79, 8'h08, 0);
		op(8'h78, 8'h18, 1);
		chk(desc_sreg, 3);
		chk({desc_req, desc_bits}, {1'b1, 7'h50});
		op(8'h7A, 8'h08, 0);
		op(8'h7B, 8'h00, 1);
		chk({desc_restore, desc_sel}, 3'h5);
		op(8'h7D, 8'h00, 1);
		chk({desc_restore, desc_sel}, 3'h6);
		current_privilege <= 2'h1;
		op(8'h7C, 8'h00, 0);
		current_privilege <= 2'h0;
		wb(0, 1);
		$display("test entry and opcodes done");
		@(posedge mclk) nmi_event <= 1'b1;
		@(posedge mclk) nmi_event <= 1'b0;
		apb(0, 8'h14, 0);
		chk(rd[1], 1);
		apb(1, 8'h04, 32'h00000002);
		for (i = 0; i < 10 && nmi_service !== 1'b1; i++) @(posedge mclk) #1;
		chk(nmi_service, 1);
		$display("test nmi latch done");
		fire <= 1'b1;
		@(posedge mclk) fire <= 1'b0;
		apb(0, 8'h14, 0);
		chk(rd[2], 1);
		op(8'hAA, 8'h00, 1);
		for (i = 0; i < 50 && ip_load !== 1'b1; i++) @(posedge mclk) #1;
		chk(instruction_pointer, 32'h0000BEE0);
		mode(0);
		chk(mgmt_space_pin, 0);
		mode(1);
		op(8'hAA, 8'h00, 1);
		mode(0);
		$display("test resume done");
		apb(1, 8'h08, 32'h00000001);
		// The mode bit lands at the access edge, so look once it has settled
		#1 chk(mgmt_cacheable, 1);
		wb(1, 1);
		wb(0, 0);
		$display("test enhanced done");
		{maskable_interrupt_pin, flags_if} <= 2'b11;
		for (i = 0; i < 10 && maskable_interrupt_pin_service !== 1'b1; i++) @(posedge mclk) #1;
		chk(maskable_interrupt_pin_service, 1);
		{maskable_interrupt_pin, flags_if} <= 2'b00;
		$display("test maskable interrupt done");
		apb(0, 8'h00, 0);
		chk(rd, 32'h00000082);
		reset <= 1'b1;
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		apb(0, 8'h00, 0);
		chk(rd, 0);
		$display("test reset done");
		stop_test;
	end
endmodule // tb_smmc_top
`default_nettype wire
